// ### logic/operand_pkg.sv
// Constants and types shared by the ALU flag and operand resolver.
// Assumes one core clock and a synchronous active-low reset.
package operand_pkg;
  // ----------------------------------------------------------------
  // Register port offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_FLAGS    = 4'h0;
  localparam logic [3:0] OFS_BANK     = 4'h1;
  localparam logic [3:0] OFS_ACC      = 4'h2;
  localparam logic [3:0] OFS_CFG      = 4'h3;
  localparam logic [3:0] OFS_PTR_BASE = 4'h4;
  localparam logic [3:0] OFS_PTR_LAST = 4'h9;
  // ----------------------------------------------------------------
  // Flag positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_HC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_SE = 3;
  localparam int FLG_N = 4;
  localparam logic [4:0]  FLAGS_RST = 5'h00;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [11:0] PTR_RST   = 12'h000;
  // ----------------------------------------------------------------
  // Data space locations
  // ----------------------------------------------------------------
  localparam logic [11:0] FLAGS_DATA_ADDR = 12'hfd0;
  localparam logic [11:0] PTR_SFR_BASE    = 12'hfc0;
  localparam logic [11:0] VIRT_BASE       = 12'hfe0;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
  localparam logic [7:0]  ACCESS_SPLIT_X  = 8'h60;
  localparam logic [7:0]  INDEX_LIMIT     = 8'h5f;
  localparam logic [2:0]  VK_PLAIN = 3'h0;
  localparam logic [2:0]  VK_POST_INCREMENT_OPERAND = 3'h1;
  localparam logic [2:0]  VK_POST_DECREMENT_OPERAND = 3'h2;
  localparam logic [2:0]  VK_PRE_INCREMENT_OPERAND = 3'h3;
  localparam logic [2:0]  VK_PLUSACC = 3'h4;
  // ----------------------------------------------------------------
  // Operations and addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR, OP_RLC, OP_RRC,
    OP_SWAP, OP_BSET, OP_BCLR, OP_MOVE, OP_JUMP
  } alu_op_t;
  typedef enum logic [1:0] {
    AM_INHERENT, AM_LITERAL, AM_DIRECT, AM_FULL
  } addr_mode_t;
endpackage : operand_pkg

// ### logic/alu_flags_and_operand_addressing.sv
// ALU condition flags and data operand address resolution.
// Assumes the decoder presents one instruction per op_valid cycle with
// the operand byte already fetched, and that memory acts on the outputs.
//
// The register addresses and the address-and-strobe port were decided locally.

module alu_flags_and_operand_addressing (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // Register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Instruction from decoder
  input  wire logic                  op_valid,
  input  wire operand_pkg::alu_op_t  op_code,
  input  wire operand_pkg::addr_mode_t op_mode,
  input  wire logic [7:0]            op_file_addr,
  input  wire logic [11:0]           op_full_addr,
  input  wire logic                  op_access_bit,
  input  wire logic                  op_has_dest,
  input  wire logic                  op_dest_bit,
  input  wire logic                  op_implicit_file,
  input  wire logic [2:0]            op_bit_sel,
  input  wire logic [7:0]            op_file_data,
  input  wire logic [19:0]           op_jump_literal,
  // Results toward memory and sequencer
  output logic [11:0]                data_addr,
  output logic [7:0]                 result_data,
  output logic                       file_wr,
  output logic                       acc_wr,
  output logic                       op_done,
  output logic                       jump_valid,
  output logic [19:0]                jump_addr,
  output logic [4:0]                 flags_out
);
  import operand_pkg::*;

  typedef struct packed {
    logic [4:0]       flags;
    logic [3:0]       bank;
    logic [7:0]       acc;
    logic             ext;
    logic [2:0][11:0] ptr;
    logic [11:0]      addr;
    logic [7:0]       result;
    logic             file_wr;
    logic             acc_wr;
    logic             done;
    logic             jump;
    logic [19:0]      jaddr;
    logic [7:0]       rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {sign_error, half_carry, carry, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
  endfunction : add8

  // Returns {hit, pointer index, alias kind}
  function automatic logic [5:0] virt_decode(input logic [11:0] a);
    logic [11:0] d;
    d = a - VIRT_BASE;
    if (a >= VIRT_BASE && d[11:3] < 9'd3 && d[2:0] <= VK_PLUSACC)
      return {1'b1, d[4:3], d[2:0]};
    return 6'h00;
  endfunction : virt_decode

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [11:0] base_addr;
  logic [11:0] eff_addr;
  logic [5:0]  vd;
  logic [1:0]  pi;
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic [10:0] sum;
  logic [4:0]  fl;
  logic        affects;
  logic        to_file;
  logic [11:0] psfr;

  always_comb begin
    st_next = st_reg;
    base_addr = 12'h000;
    eff_addr = 12'h000;
    vd = 6'h00;
    pi = 2'h0;
    opnd = op_file_data;
    res = 8'h00;
    sum = 11'h000;
    fl = st_reg.flags;
    affects = 1'b0;
    to_file = 1'b0;
    psfr = 12'h000;
    st_next.done = 1'b0;
    st_next.jump = 1'b0;
    st_next.file_wr = 1'b0;
    st_next.acc_wr = 1'b0;
    st_next.rdata = 8'h00;

    // Register port; an instruction in the same cycle wins below
    if (reg_wr) begin
      case (reg_addr)
        OFS_FLAGS: st_next.flags = reg_wdata[4:0];
        OFS_BANK:  st_next.bank = reg_wdata[3:0];
        OFS_ACC:   st_next.acc = reg_wdata;
        OFS_CFG:   st_next.ext = reg_wdata[0];
        default: begin
          if (reg_addr >= OFS_PTR_BASE && reg_addr <= OFS_PTR_LAST) begin
            psfr = {8'h00, reg_addr - OFS_PTR_BASE};
            if (psfr[0])
              st_next.ptr[psfr[2:1]][11:8] = reg_wdata[3:0];
            else
              st_next.ptr[psfr[2:1]][7:0] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_FLAGS: st_next.rdata = {3'h0, st_reg.flags};
        OFS_BANK:  st_next.rdata = {4'h0, st_reg.bank};
        OFS_ACC:   st_next.rdata = st_reg.acc;
        OFS_CFG:   st_next.rdata = {7'h00, st_reg.ext};
        default: begin
          if (reg_addr >= OFS_PTR_BASE && reg_addr <= OFS_PTR_LAST) begin
            psfr = {8'h00, reg_addr - OFS_PTR_BASE};
            st_next.rdata = psfr[0] ?
              {4'h0, st_reg.ptr[psfr[2:1]][11:8]} :
              st_reg.ptr[psfr[2:1]][7:0];
          end
        end
      endcase
    end

    if (op_valid) begin
      // Address resolution
      case (op_mode)
        AM_DIRECT: begin
          if (st_reg.ext && !op_access_bit && op_file_addr <= INDEX_LIMIT)
            base_addr = st_reg.ptr[2] + {4'h0, op_file_addr};
          else if (op_access_bit)
            base_addr = {st_reg.bank, op_file_addr};
          else if (op_file_addr <
                   (st_reg.ext ? ACCESS_SPLIT_X : ACCESS_SPLIT))
            base_addr = {4'h0, op_file_addr};
          else
            base_addr = {4'hf, op_file_addr};
        end
        AM_FULL: base_addr = op_full_addr;
        AM_LITERAL: opnd = op_file_addr;
        AM_INHERENT: opnd = st_reg.acc;
        default: base_addr = 12'h000;
      endcase
      eff_addr = base_addr;
      vd = virt_decode(base_addr);
      pi = vd[4:3];
      // Indirect: pointer forms the target, plus one for pre-increment, plus signed acc for PLUSACC
      if (vd[5] && (op_mode == AM_DIRECT || op_mode == AM_FULL)) begin
        case (vd[2:0])
          VK_PRE_INCREMENT_OPERAND: eff_addr = st_reg.ptr[pi] + 12'h001;
          VK_PLUSACC:
            eff_addr = st_reg.ptr[pi] + {{4{st_reg.acc[7]}}, st_reg.acc};
          default: eff_addr = st_reg.ptr[pi];
        endcase
        // Whole-pair adjust, flags untouched
        case (vd[2:0])
          VK_POST_INCREMENT_OPERAND, VK_PRE_INCREMENT_OPERAND:
            st_next.ptr[pi] = st_reg.ptr[pi] + 12'h001;
          VK_POST_DECREMENT_OPERAND:
            st_next.ptr[pi] = st_reg.ptr[pi] - 12'h001;
          default: st_next.ptr[pi] = st_reg.ptr[pi];
        endcase
      end

      // ALU and flags
      case (op_code)
        OP_ADD: begin
          sum = add8(opnd, st_reg.acc, 1'b0);
          affects = 1'b1;
        end
        OP_SUB: begin
          sum = add8(opnd, ~st_reg.acc, 1'b1);
          affects = 1'b1;
        end
        OP_AND: res = opnd & st_reg.acc;
        OP_IOR: res = opnd | st_reg.acc;
        OP_XOR: res = opnd ^ st_reg.acc;
        OP_CLR: res = 8'h00;
        OP_RLC: res = {opnd[6:0], st_reg.flags[FLG_C]};
        OP_RRC: res = {st_reg.flags[FLG_C], opnd[7:1]};
        OP_SWAP: res = {opnd[3:0], opnd[7:4]};
        OP_BSET: res = opnd | (8'h01 << op_bit_sel);
        OP_BCLR: res = opnd & ~(8'h01 << op_bit_sel);
        OP_MOVE: res = opnd;
        default: res = 8'h00;
      endcase
      case (op_code)
        OP_ADD, OP_SUB: begin
          res = sum[7:0];
          fl[FLG_C] = sum[8];
          fl[FLG_HC] = sum[9];
          fl[FLG_SE] = sum[10];
          fl[FLG_N] = res[7];
          fl[FLG_Z] = (res == 8'h00);
        end
        OP_AND, OP_IOR, OP_XOR: begin
          affects = 1'b1;
          fl[FLG_N] = res[7];
          fl[FLG_Z] = (res == 8'h00);
        end
        OP_CLR: begin
          affects = 1'b1;
          fl[FLG_Z] = 1'b1;
        end
        OP_RLC, OP_RRC: begin
          affects = 1'b1;
          fl[FLG_C] = (op_code == OP_RLC) ? opnd[7] : opnd[0];
          fl[FLG_N] = res[7];
          fl[FLG_Z] = (res == 8'h00);
        end
        default: fl = st_next.flags;
      endcase

      // Destination
      if (op_code == OP_JUMP) begin
        st_next.jump = 1'b1;
        st_next.jaddr = op_jump_literal;
      end else if (op_mode == AM_LITERAL || op_mode == AM_INHERENT)
        to_file = 1'b0;
      else if (op_has_dest)
        to_file = op_dest_bit;
      else
        to_file = op_implicit_file;

      st_next.flags = fl;
      st_next.addr = eff_addr;
      st_next.result = res;
      st_next.done = 1'b1;
      if (op_code != OP_JUMP) begin
        if (to_file && eff_addr == FLAGS_DATA_ADDR) begin
          // Computed byte is dropped when the op owns the flags
          if (!affects)
            st_next.flags = res[4:0];
        end else if (to_file) begin
          st_next.file_wr = 1'b1;
          psfr = eff_addr - PTR_SFR_BASE;
          if (eff_addr >= PTR_SFR_BASE && psfr < 12'h006) begin
            if (psfr[0])
              st_next.ptr[psfr[2:1]][11:8] = res[3:0];
            else
              st_next.ptr[psfr[2:1]][7:0] = res;
          end
        end else begin
          st_next.acc_wr = 1'b1;
          st_next.acc = res;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.flags <= FLAGS_RST;
      st_reg.acc <= ACC_RST;
      st_reg.bank <= BANK_RST;
      st_reg.ptr <= {3{PTR_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign data_addr = st_reg.addr;
  assign result_data = st_reg.result;
  assign file_wr = st_reg.file_wr;
  assign acc_wr = st_reg.acc_wr;
  assign op_done = st_reg.done;
  assign jump_valid = st_reg.jump;
  assign jump_addr = st_reg.jaddr;
  assign flags_out = st_reg.flags;

  // Plain literal sum, kept apart from the datapath adder
  logic [8:0] lit_sum;
  assign lit_sum = {1'b0, op_file_addr} + {1'b0, st_reg.acc};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_flags_read_zero: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    reg_rd && reg_addr == OFS_FLAGS |=> reg_rdata[7:5] == 3'h0 &&
      reg_rdata[4:0] == $past(flags_out))
    else $error("flags read shows wrong value");

  chk_add_carry: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_code == OP_ADD && op_mode == AM_LITERAL |=>
      flags_out[FLG_C] == $past(lit_sum[8]))
    else $error("add carry mismatch");

  chk_add_zero_neg: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_code == OP_ADD && op_mode == AM_LITERAL |=>
      flags_out[FLG_Z] == (result_data == 8'h00) &&
      flags_out[FLG_N] == result_data[7] && acc_wr &&
      result_data == $past(lit_sum[7:0]))
    else $error("zero or negative flag mismatch");

  chk_sub_borrow: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_code == OP_SUB && op_mode == AM_LITERAL &&
      op_file_addr == st_reg.acc |=>
      flags_out[FLG_C] && flags_out[FLG_HC] && flags_out[FLG_Z])
    else $error("equal subtract must give no borrow");

  chk_clear_flags: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_code == OP_CLR && op_mode == AM_FULL &&
      op_full_addr == FLAGS_DATA_ADDR && op_has_dest && op_dest_bit |=>
      flags_out == ($past(flags_out) | 5'h04) && !file_wr)
    else $error("clear of flags register wrong");

  chk_bank_direct: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_mode == AM_DIRECT && op_access_bit &&
      virt_decode({st_reg.bank, op_file_addr}) == 6'h00 |=>
      data_addr == {$past(st_reg.bank), $past(op_file_addr)})
    else $error("banked address wrong");

  chk_access_bank: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_mode == AM_DIRECT && !op_access_bit && !st_reg.ext &&
      op_file_addr < ACCESS_SPLIT |=> data_addr[11:8] == 4'h0)
    else $error("access bank address wrong");

  chk_post_inc: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_mode == AM_FULL && op_full_addr == VIRT_BASE + 12'h001 &&
      !reg_wr |=>
      data_addr == $past(st_reg.ptr[0]) &&
      st_reg.ptr[0] == $past(st_reg.ptr[0]) + 12'h001)
    else $error("post increment wrong");

  chk_jump_addr: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    op_valid && op_code == OP_JUMP |=> jump_valid && !file_wr &&
      jump_addr == $past(op_jump_literal) ##1
      !jump_valid || $past(op_valid && op_code == OP_JUMP))
    else $error("jump address wrong");

endmodule : alu_flags_and_operand_addressing

// ### verification/tb_top.sv
// Self-checking bench for the ALU flag and operand resolver.
// Assumes operand_pkg and the design module are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import operand_pkg::*;
  // ------------------------------------------------------------
  // Signals and models
  // ------------------------------------------------------------
  logic        clk_sys, resetn, reg_wr, reg_rd, op_valid;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, op_file_addr, op_file_data;
  logic [7:0]  result_data;
  logic        op_access_bit, op_has_dest, op_dest_bit, op_implicit_file;
  logic        file_wr, acc_wr, op_done, jump_valid;
  alu_op_t     op_code;
  addr_mode_t  op_mode;
  logic [11:0] op_full_addr, data_addr;
  logic [2:0]  op_bit_sel;
  logic [19:0] op_jump_literal, jump_addr;
  logic [4:0]  flags_out, flg_m;
  logic [7:0]  acc_m;
  logic [3:0]  bank_m;
  int          err_total, checks_done, cyc, seed;

  alu_flags_and_operand_addressing dut_u (
    .clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .op_valid, .op_code, .op_mode, .op_file_addr,
    .op_full_addr, .op_access_bit, .op_has_dest, .op_dest_bit,
    .op_implicit_file, .op_bit_sel, .op_file_data, .op_jump_literal,
    .data_addr, .result_data, .file_wr, .acc_wr, .op_done,
    .jump_valid, .jump_addr, .flags_out
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Hang guard well above the under one thousand cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // Reference and checks
  // ------------------------------------------------------------
  function automatic logic [12:0] alu_ref(input alu_op_t c,
                                          input logic [7:0] a, w,
                                          input logic [4:0] f);
    logic [8:0] s;
    logic [7:0] b, r;
    logic       ci;
    b  = (c == OP_SUB) ? ~w : w;
    ci = (c == OP_SUB);
    s  = a + b + ci;
    r  = s[7:0];
    case (c)
      OP_ADD, OP_SUB: begin
        f[FLG_C]  = s[8];
        f[FLG_HC] = ((a[3:0] + b[3:0] + ci) > 5'h0f);
        f[FLG_SE] = s[8] ^ ((a[6:0] + b[6:0] + ci) > 8'h7f);
      end
      OP_AND: r = a & w;
      OP_IOR: r = a | w;
      OP_XOR: r = a ^ w;
      OP_RLC: begin
        r = {a[6:0], f[FLG_C]};
        f[FLG_C] = a[7];
      end
      default: begin
        r = {f[FLG_C], a[7:1]};
        f[FLG_C] = a[0];
      end
    endcase
    f[FLG_Z] = (r == 8'h00);
    f[FLG_N] = r[7];
    return {f, r};
  endfunction : alu_ref

  task automatic chk(input string nm, input logic [19:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : rw

  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask : rchk

  // ctl packs access, has_dest, dest_bit, implicit_file
  task automatic op(input alu_op_t c, input addr_mode_t m,
                    input logic [7:0] fa, fd, input logic [11:0] fu,
                    input logic [3:0] ctl);
    @(posedge clk_sys);
    op_valid        <= 1'b1;
    op_code         <= c;
    op_mode         <= m;
    op_file_addr    <= fa;
    op_file_data    <= fd;
    op_full_addr    <= fu;
    op_bit_sel      <= fa[2:0];
    op_jump_literal <= {fu, fa};
    {op_access_bit, op_has_dest, op_dest_bit, op_implicit_file} <= ctl;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk("op_done", 20'h1, op_done);
  endtask : op

  task automatic run_alu(input alu_op_t c, input addr_mode_t m,
                         input logic [7:0] fa, fd,
                         input logic [11:0] fu, input logic [3:0] ctl);
    logic [12:0] e;
    logic        tf;
    e  = alu_ref(c, (m == AM_LITERAL) ? fa : (m == AM_INHERENT) ? acc_m : fd,
                 acc_m, flg_m);
    tf = (m == AM_DIRECT || m == AM_FULL) && (ctl[2] ? ctl[1] : ctl[0]);
    op(c, m, fa, fd, fu, ctl);
    chk("result", e[7:0], result_data);
    chk("flags", e[12:8], flags_out);
    chk("file_wr", tf, file_wr);
    chk("acc_wr", !tf, acc_wr);
    if (m == AM_DIRECT) begin
      chk("addr", ctl[3] ? {bank_m, fa} : {{4{fa[7]}}, fa}, data_addr);
    end else if (m == AM_FULL) begin
      chk("addr", fu, data_addr);
    end
    flg_m = e[12:8];
    if (!tf) acc_m = e[7:0];
  endtask : run_alu
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    alu_op_t     c;
    alu_op_t     ops[7] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
                            OP_RLC, OP_RRC};
    logic [7:0]  cf[4] = '{8'h7f, 8'h00, 8'h0f, 8'h80};
    logic [7:0]  cw[4] = '{8'h01, 8'h01, 8'h01, 8'h80};
    logic [11:0] vad[5] = '{12'hfe1, 12'hfea, 12'hff3, 12'hfe4, 12'hfe8};
    logic [11:0] vex[5] = '{12'h0ff, 12'h100, 12'h000, 12'h0ff, 12'h0ff};
    logic [11:0] vpe[5] = '{12'h100, 12'h0ff, 12'h000, 12'h100, 12'h0ff};
    int          vpn[5] = '{0, 1, 2, 0, 1};
    logic [12:0] ex;
    seed = 32'hba4a;
    {reg_wr, reg_rd, op_valid, op_access_bit, op_has_dest} = '0;
    {op_dest_bit, op_implicit_file, op_bit_sel} = '0;
    {reg_addr, reg_wdata, op_file_addr, op_file_data} = '0;
    {op_full_addr, op_jump_literal} = '0;
    op_code = OP_ADD;
    op_mode = AM_DIRECT;
    resetn  = 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("flags_rst", FLAGS_RST, flags_out);
    rchk("ptr_rst", OFS_PTR_BASE, 8'h00);
    rw(OFS_FLAGS, 8'hff);
    rchk("flags_rd", OFS_FLAGS, 8'h1f);
    rw(4'hb, 8'h55);
    rchk("unmapped", 4'hb, 8'h00);
    flg_m  = 5'h1f;
    bank_m = 4'h3;
    rw(OFS_BANK, 8'h03);
    // Corners first, then random traffic
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      c = ops[r[2:0] % 3'd7];
      if (i % 16 == 15) begin
        bank_m = r[31:28] % 4'd15;
        rw(OFS_BANK, {4'h0, bank_m});
      end
      if (i < 4) begin
        acc_m = cw[i];
        rw(OFS_ACC, acc_m);
        run_alu(i[0] ? OP_SUB : OP_ADD, AM_DIRECT, 8'h20, cf[i], 12'h0, 4'b0110);
      end else begin
        run_alu(c, (r[3] && c != OP_RLC && c != OP_RRC) ? AM_LITERAL
                : AM_DIRECT, r[4] ? {r[15], 1'b0, r[13:8]} : {1'b0, r[14:8]},
                r[23:16], 12'h0, r[7:4]);
      end
    end
    // Accumulator-only operand, then an equal subtract
    run_alu(OP_ADD, AM_INHERENT, 8'h00, 8'h00, 12'h0, 4'b0110);
    run_alu(OP_SUB, AM_LITERAL, acc_m, 8'h00, 12'h0, 4'b0000);
    // Embedded full address beside a live bank select
    run_alu(OP_ADD, AM_FULL, 8'h00, 8'h01, 12'h234, 4'b1110);
    // Flag-neutral byte ops, then a plain clear
    op(OP_SWAP, AM_DIRECT, 8'h21, 8'h3c, 12'h0, 4'b0110);
    chk("swap", 20'hc3, result_data);
    chk("swap_fl", flg_m, flags_out);
    op(OP_BCLR, AM_DIRECT, 8'h22, 8'hff, 12'h0, 4'b0110);
    chk("bclr", 20'hfb, result_data);
    chk("bclr_fl", flg_m, flags_out);
    op(OP_CLR, AM_DIRECT, 8'h23, 8'h77, 12'h0, 4'b0110);
    flg_m[FLG_Z] = 1'b1;
    chk("clr_res", 20'h0, result_data);
    chk("clr_fl", flg_m, flags_out);
    // Flag-affecting results, then a bit set byte, into the flags register
    op(OP_ADD, AM_FULL, 8'h00, 8'h00, FLAGS_DATA_ADDR, 4'b0110);
    chk("fl_wr", 20'h0, file_wr);
    ex    = alu_ref(OP_ADD, 8'h00, acc_m, flg_m);
    flg_m = ex[12:8];
    chk("fl_add", flg_m, flags_out);
    rw(OFS_FLAGS, 8'h0a);
    op(OP_CLR, AM_FULL, 8'h00, 8'h77, FLAGS_DATA_ADDR, 4'b0110);
    chk("fl_clr", 20'h0e, flags_out);
    op(OP_BSET, AM_FULL, 8'h03, 8'h01, FLAGS_DATA_ADDR, 4'b0110);
    chk("fl_bset", 20'h09, flags_out);
    flg_m = 5'h09;
    // Pointer aliases; bank and access bit must not matter
    rw(OFS_BANK, 8'h05);
    rw(OFS_ACC, 8'hff);
    acc_m = 8'hff;
    for (int n = 0; n < 3; n++) begin
      rw(4'(OFS_PTR_BASE + 2 * n), n == 0 ? 8'hff : n == 1 ? 8'h00 : 8'hff);
      rw(4'(OFS_PTR_BASE + 2 * n + 1),
         n == 0 ? 8'hf0 : n == 1 ? 8'h01 : 8'h0f);
    end
    rchk("ptr_hi", OFS_PTR_BASE + 4'h1, 8'h00);
    for (int k = 0; k < 5; k++) begin
      op(OP_MOVE, AM_FULL, 8'h00, 8'h3c, vad[k], 4'b1110);
      chk("ind_addr", vex[k], data_addr);
      chk("ind_flags", flg_m, flags_out);
      rchk("ptr_lo", 4'(OFS_PTR_BASE + 2 * vpn[k]), vpe[k][7:0]);
      rchk("ptr_hi", 4'(OFS_PTR_BASE + 2 * vpn[k] + 1), {4'h0, vpe[k][11:8]});
    end
    // Instruction write into a pointer byte
    run_alu(OP_ADD, AM_FULL, 8'h00, 8'h10, PTR_SFR_BASE + 12'h4, 4'b0110);
    rchk("ptr_wr", OFS_PTR_BASE + 4'h4, 8'h0f);
    // Indexed literal offset with the extended set on
    rw(OFS_PTR_BASE + 4'h4, 8'h00);
    rw(OFS_PTR_BASE + 4'h5, 8'h02);
    rw(OFS_CFG, 8'h01);
    op(OP_MOVE, AM_DIRECT, 8'h5f, 8'h00, 12'h0, 4'b0110);
    chk("idx_addr", 20'h25f, data_addr);
    op(OP_MOVE, AM_DIRECT, 8'h60, 8'h00, 12'h0, 4'b0110);
    chk("idx_split", 20'hf60, data_addr);
    rw(OFS_CFG, 8'h00);
    // Program address literal
    op(OP_JUMP, AM_LITERAL, 8'hcd, 8'h00, 12'hab5, 4'b0000);
    chk("jump_v", 20'h1, jump_valid);
    chk("jump_a", 20'hab5cd, jump_addr);
    test_done();
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
endmodule : tb_top
